// file: line_delay_pkg.sv
package line_delay_pkg;

  // datapath and length widths
  localparam int DATA_W        = 10;
  localparam int LEN_W         = 11;
  localparam int FILL_W        = LEN_W + 1;
  localparam int FIXED_STAGES  = 2;
  localparam int RING_DEPTH    = 2 ** LEN_W;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SYNC_STAGES   = 2;

  // wishbone geometry
  localparam int WB_ADDR_W = 8;
  localparam int WB_DATA_W = 32;
  localparam int WB_SEL_W  = 4;

  // register byte offsets
  localparam logic [WB_ADDR_W-1:0] LENGTH_OFS = 8'h00;
  localparam logic [WB_ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [WB_ADDR_W-1:0] STEPS_OFS  = 8'h08;

  // status field positions
  localparam int ST_LOOP_BIT    = 0;
  localparam int ST_FROZEN_BIT  = 1;
  localparam int ST_FILLED_BIT  = 2;
  localparam int ST_PENDING_BIT = 3;
  localparam int ST_DRIVE_BIT   = 4;
  localparam int ST_RISING_BIT  = 5;

  // values after reset
  localparam logic [LEN_W-1:0]     LEN_RESET   = 11'h000;
  localparam logic [DATA_W-1:0]    DATA_RESET  = 10'h000;
  localparam logic [FILL_W-1:0]    FILL_RESET  = 12'h000;
  localparam logic [WB_DATA_W-1:0] WORD_RESET  = 32'h0000_0000;
  localparam logic                 GATE_RESET  = 1'b0;

  typedef logic [DATA_W-1:0] sample_t;
  typedef logic [LEN_W-1:0]  length_t;

  // every pin that crosses into sys_clk, synchronised as one bundle
  typedef struct packed {
    logic    line_clk;
    logic    edge_polarity_select;
    logic    clock_gate_n;
    logic    length_load_n;
    logic    loop_mode_select;
    logic    output_enable_n;
    length_t delay_length_value;
    sample_t sample_in;
  } line_pins_s;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_e;

endpackage : line_delay_pkg

// file: two_flop_sync.sv
module two_flop_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : two_flop_sync

// file: sample_ring.sv
module sample_ring #(
  parameter int DEPTH  = 2048,
  parameter int WIDTH  = 10,
  parameter int IDX_W  = 11
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] cell_q [DEPTH];

  // cleared on reset so the tail never reads unknown words
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        cell_q[i] <= '0;
      end
    end else if (wr_en) begin
      cell_q[wr_idx] <= wr_data;
    end
  end

  // read is asynchronous; the caller registers it
  assign rd_data = cell_q[rd_idx];

endmodule : sample_ring

// file: programmable_line_delay_buffer.sv
module programmable_line_delay_buffer (
  input  wire logic                                      sys_clk,
  input  wire logic                                      reset,
  input  wire logic                                      line_clk,
  input  wire logic                                      edge_polarity_select,
  input  wire logic                                      clock_gate_n,
  input  wire logic                                      length_load_n,
  input  wire logic                                      loop_mode_select,
  input  wire logic                                      output_enable_n,
  input  wire line_delay_pkg::length_t                   delay_length_value,
  input  wire line_delay_pkg::sample_t                   sample_in,
  output line_delay_pkg::sample_t                        sample_out,
  output logic                                           sample_out_oe,
  input  wire logic                                      wb_cyc_i,
  input  wire logic                                      wb_stb_i,
  input  wire logic                                      wb_we_i,
  input  wire logic [line_delay_pkg::WB_ADDR_W-1:0]      wb_adr_i,
  input  wire logic [line_delay_pkg::WB_SEL_W-1:0]       wb_sel_i,
  input  wire logic [line_delay_pkg::WB_DATA_W-1:0]      wb_dat_i,
  output logic      [line_delay_pkg::WB_DATA_W-1:0]      wb_dat_o,
  output logic                                           wb_ack_o
);
  import line_delay_pkg::*;

  // pin bundle and its synchronised copy
  line_pins_s pins_raw;
  line_pins_s pins_sync;

  // line clock edge detection
  logic line_clk_prev_q;
  logic clk_rise;
  logic clk_fall;
  logic active_edge;
  logic run_step;
  logic gate_q;

  // datapath
  sample_t in_d;
  sample_t in_q;
  sample_t out_d;
  sample_t out_q;
  sample_t ring_rd;
  length_t wp_q;
  length_t wp_d;
  length_t rd_idx;
  logic    len_zero;

  // length control
  length_t     len_q;
  length_t     len_d;
  length_t     bus_len_q;
  length_t     bus_len_d;
  logic        pend_q;
  logic        pend_set;
  logic        pend_clr;
  logic        pin_load;
  logic        bus_load;
  logic        load_any;
  logic        len_valid_q;
  logic [FILL_W-1:0] fill_cnt_q;
  logic [FILL_W-1:0] len_total;
  logic        filled;

  // output drive
  logic oe_q;
  logic oe_d;

  // bus slave
  bus_state_e           bus_q;
  logic                 bus_take;
  logic                 hit_len;
  logic                 hit_status;
  logic                 hit_steps;
  logic                 wr_len;
  logic [WB_DATA_W-1:0] rd_word;
  logic [WB_DATA_W-1:0] len_word;
  logic [WB_DATA_W-1:0] status_word;
  logic [WB_DATA_W-1:0] step_cnt_q;
  logic [WB_DATA_W-1:0] step_cnt_d;
  logic [WB_DATA_W-1:0] dat_q;
  logic                 ack_q;

  // gather pins so one synchroniser keeps them aligned with the line clock
  assign pins_raw = '{
    line_clk:             line_clk,
    edge_polarity_select: edge_polarity_select,
    clock_gate_n:         clock_gate_n,
    length_load_n:        length_load_n,
    loop_mode_select:     loop_mode_select,
    output_enable_n:      output_enable_n,
    delay_length_value:   delay_length_value,
    sample_in:            sample_in
  };

  two_flop_sync #(
    .WIDTH ($bits(line_pins_s))
  ) u_pin_sync (
    .clk      (sys_clk),
    .reset    (reset),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  // history of the synchronised line clock for edge detection
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      line_clk_prev_q <= 1'b0;
    end else begin
      line_clk_prev_q <= pins_sync.line_clk;
    end
  end

  // edge pulses; data and strobes share the same sync delay as the clock
  assign clk_rise    = pins_sync.line_clk & ~line_clk_prev_q;
  assign clk_fall    = ~pins_sync.line_clk & line_clk_prev_q;
  assign active_edge = pins_sync.edge_polarity_select ? clk_rise : clk_fall;
  // one enable for every stepping register below
  assign run_step    = active_edge & ~gate_q;

  // gate is sampled on every active edge, even while frozen, so it can thaw
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gate_q <= GATE_RESET;
    end else if (active_edge) begin
      gate_q <= pins_sync.clock_gate_n;
    end
  end

  // input stage: external word in delay mode, own output in loop mode
  assign in_d = pins_sync.loop_mode_select ? out_q : pins_sync.sample_in;

  // read sits len_q words behind write; wraps on the index width
  assign rd_idx = wp_q - len_q;

  // zero length bypasses the memory, leaving only the two fixed stages
  assign len_zero = (len_q == LEN_RESET);
  assign out_d    = len_zero ? in_q : ring_rd;

  sample_ring #(
    .DEPTH (RING_DEPTH),
    .WIDTH (DATA_W),
    .IDX_W (LEN_W)
  ) u_ring (
    .clk     (sys_clk),
    .reset   (reset),
    .wr_en   (run_step),
    .wr_idx  (wp_q),
    .wr_data (in_q),
    .rd_idx  (rd_idx),
    .rd_data (ring_rd)
  );

  // fixed stage ahead of the memory
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      in_q <= DATA_RESET;
    end else if (run_step) begin
      in_q <= in_d;
    end
  end

  // fixed stage after the memory; it alone feeds the output pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_q <= DATA_RESET;
    end else if (run_step) begin
      out_q <= out_d;
    end
  end

  // write index wraps on its own width, so no compare is needed
  assign wp_d = wp_q + 1'b1;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wp_q <= LEN_RESET;
    end else if (run_step) begin
      wp_q <= wp_d;
    end
  end

  // length loads: pin strobe beats a staged bus value on the same edge
  assign pin_load = run_step & ~pins_sync.length_load_n;
  assign bus_load = run_step & pend_q & pins_sync.length_load_n;
  assign load_any = pin_load | bus_load;
  assign len_d    = pin_load ? pins_sync.delay_length_value : bus_len_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      len_q <= LEN_RESET;
    end else if (load_any) begin
      len_q <= len_d;
    end
  end

  // staged bus length; a new write wins over the clear on the loading edge
  assign pend_set = wr_len;
  assign pend_clr = run_step;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend_q <= 1'b0;
    end else if (pend_set) begin
      pend_q <= 1'b1;
    end else if (pend_clr) begin
      pend_q <= 1'b0;
    end
  end

  // fill tracking: words are trusted only after a load and a full pass
  assign len_total = {1'b0, len_q} + FILL_W'(FIXED_STAGES);
  assign filled    = len_valid_q & (fill_cnt_q == len_total);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      len_valid_q <= 1'b0;
    end else if (load_any) begin
      len_valid_q <= 1'b1;
    end
  end

  // restarts on every load and saturates once the pipeline is full
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fill_cnt_q <= FILL_RESET;
    end else if (load_any) begin
      fill_cnt_q <= FILL_RESET;
    end else if (run_step && fill_cnt_q != len_total) begin
      fill_cnt_q <= fill_cnt_q + 1'b1;
    end
  end

  // output enable follows the pin on sys_clk, not gated by the line clock
  assign oe_d = ~pins_sync.output_enable_n;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  // data keeps moving while the pin floats; only the enable changes
  assign sample_out    = out_q;
  assign sample_out_oe = oe_q;

  // count of active edges that actually stepped the buffer
  assign step_cnt_d = step_cnt_q + 1'b1;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      step_cnt_q <= WORD_RESET;
    end else if (run_step) begin
      step_cnt_q <= step_cnt_d;
    end
  end

  // bus decode; only exact aligned byte addresses hit
  assign bus_take   = (bus_q == BUS_IDLE) & wb_cyc_i & wb_stb_i;
  assign hit_len    = (wb_adr_i == LENGTH_OFS);
  assign hit_status = (wb_adr_i == STATUS_OFS);
  assign hit_steps  = (wb_adr_i == STEPS_OFS);
  assign wr_len     = bus_take & wb_we_i & hit_len & (wb_sel_i[0] | wb_sel_i[1]);

  // byte lanes: lane 0 holds bits 7:0, lane 1 holds bits 10:8
  assign bus_len_d[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0] : bus_len_q[7:0];
  assign bus_len_d[10:8] = wb_sel_i[1] ? wb_dat_i[10:8] : bus_len_q[10:8];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_len_q <= LEN_RESET;
    end else if (wr_len) begin
      bus_len_q <= bus_len_d;
    end
  end

  // read words; unused bits read as zero
  assign len_word    = {5'h00, bus_len_q, 5'h00, len_q};
  assign status_word = {26'h000_0000,
                        pins_sync.edge_polarity_select,
                        oe_q,
                        pend_q,
                        filled,
                        gate_q,
                        pins_sync.loop_mode_select};
  assign rd_word     = hit_len    ? len_word :
                       hit_status ? status_word :
                       hit_steps  ? step_cnt_q :
                       WORD_RESET;

  // one-cycle answer; unmapped addresses are acked with zero data
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_q <= BUS_IDLE;
      ack_q <= 1'b0;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (bus_take) begin
            bus_q <= BUS_ACK;
            ack_q <= 1'b1;
          end
        end
        BUS_ACK: begin
          bus_q <= BUS_IDLE;
          ack_q <= 1'b0;
        end
        default: begin
          bus_q <= BUS_IDLE;
          ack_q <= 1'b0;
        end
      endcase
    end
  end

  // read word captured with the answer; writes return zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dat_q <= WORD_RESET;
    end else if (bus_take) begin
      dat_q <= wb_we_i ? WORD_RESET : rd_word;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule : programmable_line_delay_buffer

// file: line_delay_properties.sv
module line_delay_properties (
  input wire logic                                 sys_clk,
  input wire logic                                 reset,
  input wire logic                                 line_clk,
  input wire logic                                 edge_polarity_select,
  input wire logic                                 clock_gate_n,
  input wire logic                                 output_enable_n,
  input wire line_delay_pkg::sample_t              sample_out,
  input wire logic                                 sample_out_oe,
  input wire logic                                 wb_cyc_i,
  input wire logic                                 wb_stb_i,
  input wire logic                                 wb_we_i,
  input wire logic [line_delay_pkg::WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [line_delay_pkg::WB_DATA_W-1:0] wb_dat_o,
  input wire logic                                 wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import line_delay_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic       prev_q;
  logic [7:0] since_q;
  logic [7:0] held_q;
  // cycles since a selected line edge and since the gate pin closed, saturating
  always_ff @(posedge sys_clk) begin
    prev_q <= line_clk;
    if (reset || (line_clk != prev_q && line_clk == edge_polarity_select)) since_q <= 8'h00;
    else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
    if (reset || !clock_gate_n) held_q <= 8'h00;
    else if (held_q != 8'hFF) held_q <= held_q + 8'h01;
  end
  oe_drive_a: assert property (!output_enable_n [*6] |-> sample_out_oe)
    else $error("output not driven while enable low");
  oe_float_a: assert property (output_enable_n [*6] |-> !sample_out_oe)
    else $error("output driven while enable high");
  frozen_hold_a: assert property (held_q > 8'h28 |-> $stable(sample_out))
    else $error("output moved while frozen");
  step_edge_a: assert property ($changed(sample_out) |-> since_q < 8'h08)
    else $error("output moved away from the selected edge");
  ack_answer_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i
      && (wb_adr_i > STEPS_OFS || wb_adr_i[1:0] != 2'b00) |-> wb_dat_o == WORD_RESET)
    else $error("unmapped read not zero");
endmodule : line_delay_properties

bind programmable_line_delay_buffer line_delay_properties i_props (
  .sys_clk(sys_clk), .reset(reset), .line_clk(line_clk),
  .edge_polarity_select(edge_polarity_select), .clock_gate_n(clock_gate_n),
  .output_enable_n(output_enable_n), .sample_out(sample_out), .sample_out_oe(sample_out_oe),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// file: line_source.sv
module line_source (
  input  wire logic               sys_clk,
  input  wire logic               run,
  input  wire logic               rising,
  output logic                    line_clk,
  output line_delay_pkg::sample_t sample_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import line_delay_pkg::*;
  int ph_q;
  initial begin
    ph_q = 0;
    line_clk = 1'b0;
    sample_in = DATA_RESET;
  end
  // line clock stands still unless running; new word only at the inactive edge
  always @(posedge sys_clk) begin
    if (run) begin
      ph_q <= (ph_q == 5) ? 0 : ph_q + 1;
      if (ph_q == 5) begin
        line_clk <= !line_clk;
        if (line_clk == rising) sample_in <= sample_in + 10'h001;
      end
    end
  end
endmodule : line_source

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import line_delay_pkg::*;
  logic                 sys_clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 run = 1'b0;
  logic                 edge_sel = 1'b1;
  logic                 gate_n = 1'b0;
  logic                 load_n = 1'b1;
  logic                 loop_mode = 1'b0;
  logic                 oe_n = 1'b0;
  length_t              len_pin = 11'h000;
  logic                 wb_cyc_i = 1'b0;
  logic                 wb_stb_i = 1'b0;
  logic                 wb_we_i = 1'b0;
  logic [WB_ADDR_W-1:0] wb_adr_i = 8'h00;
  logic [WB_SEL_W-1:0]  wb_sel_i = 4'h0;
  logic [WB_DATA_W-1:0] wb_dat_i = 32'h0000_0000;
  logic [WB_DATA_W-1:0] wb_dat_o;
  logic [WB_DATA_W-1:0] rd;
  logic                 wb_ack_o;
  logic                 line_clk;
  logic                 oe;
  sample_t              sample_in;
  sample_t              sample_out;
  int                   n_errors = 0;
  int                   tests_run = 0;

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  line_source i_src (.sys_clk(sys_clk), .run(run), .rising(edge_sel),
    .line_clk(line_clk), .sample_in(sample_in));

  programmable_line_delay_buffer i_dut (.sys_clk(sys_clk), .reset(reset),
    .line_clk(line_clk), .edge_polarity_select(edge_sel), .clock_gate_n(gate_n),
    .length_load_n(load_n), .loop_mode_select(loop_mode), .output_enable_n(oe_n),
    .delay_length_value(len_pin), .sample_in(sample_in), .sample_out(sample_out),
    .sample_out_oe(oe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check

  task automatic edges(input int n);
    repeat (n) begin
      if (edge_sel) @(posedge line_clk);
      else @(negedge line_clk);
    end
  endtask : edges

  // output settles a few system cycles after the line edge, before new data
  task automatic settle();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic wb_xfer(input logic we, input logic [WB_ADDR_W-1:0] adr,
                         input logic [WB_DATA_W-1:0] wd, output logic [WB_DATA_W-1:0] rdat);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    check(wb_ack_o === 1'b1, "bus answer");
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task automatic load(input length_t len);
    @(posedge sys_clk);
    load_n <= 1'b0;
    len_pin <= len;
    edges(1);
    @(posedge sys_clk);
    load_n <= 1'b1;
  endtask : load

  task automatic stream(input length_t len);
    edges(1);
    settle();
    check(sample_out === sample_t'(sample_in - len - 11'h001), "delayed word");
  endtask : stream

  task automatic t_delay(input length_t len, input logic rise);
    edges(1);
    @(posedge sys_clk);
    edge_sel <= rise;
    load(len);
    edges(int'(len) + 4);
    repeat (3) stream(len);
    wb_xfer(1'b0, LENGTH_OFS, WORD_RESET, rd);
    check(rd[LEN_W-1:0] === len, "active length");
    wb_xfer(1'b0, STATUS_OFS, WORD_RESET, rd);
    check(rd[ST_FILLED_BIT] === 1'b1, "pipeline filled");
    $display("delay test done, length %0d", len);
  endtask : t_delay

  task automatic t_oe();
    @(posedge sys_clk);
    oe_n <= 1'b1;
    stream(11'h005);
    check(oe === 1'b0, "output floats");
    @(posedge sys_clk);
    oe_n <= 1'b0;
    settle();
    check(oe === 1'b1, "output driven");
    $display("enable test done");
  endtask : t_oe

  task automatic t_freeze();
    sample_t v;
    edges(1);
    settle();
    v = sample_out;
    @(posedge sys_clk);
    gate_n <= 1'b1;
    edges(1);
    settle();
    check(sample_out === sample_t'(v + 10'h001), "one more step");
    edges(3);
    settle();
    check(sample_out === sample_t'(v + 10'h001), "frozen word");
    @(posedge sys_clk);
    gate_n <= 1'b0;
    edges(2);
    $display("freeze test done");
  endtask : t_freeze

  task automatic t_loop();
    sample_t seen [10];
    load(11'h003);
    edges(6);
    @(posedge sys_clk);
    loop_mode <= 1'b1;
    edges(2);
    for (int i = 0; i < 10; i++) begin
      edges(1);
      settle();
      seen[i] = sample_out;
    end
    // a five-step loop repeats with distinct neighbours
    for (int i = 0; i < 5; i++) begin
      check(seen[i + 5] === seen[i] && seen[i] !== seen[i + 1], "loop word");
    end
    @(posedge sys_clk);
    loop_mode <= 1'b0;
    $display("loop test done");
  endtask : t_loop

  task automatic t_bus();
    wb_xfer(1'b0, 8'h0C, WORD_RESET, rd);
    check(rd === WORD_RESET, "unmapped read");
    wb_xfer(1'b1, LENGTH_OFS, 32'h0000_0009, rd);
    edges(2);
    wb_xfer(1'b0, LENGTH_OFS, WORD_RESET, rd);
    check(rd[LEN_W-1:0] === 11'h009, "bus length");
    wb_xfer(1'b0, STATUS_OFS, WORD_RESET, rd);
    check(rd[ST_RISING_BIT] === 1'b1 && rd[ST_FROZEN_BIT] === 1'b0, "status");
    $display("bus test done");
  endtask : t_bus

  // longest case is the full-length delay, about a third of this span
  initial begin
    #300us;
    n_errors++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    run <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_delay(11'h000, 1'b1);
    t_delay(11'h7FF, 1'b0);
    t_delay(11'h005, 1'b1);
    t_oe();
    t_freeze();
    t_loop();
    t_bus();
    summarize();
  end
endmodule : tb_top
